// ### bench/dps_sequencer_assertions.sv
// Checker for the power-up sequencer, bound to the top module's ports.
// Assumes straps stay stable around reset release.
`timescale 1ns/100ps
module dps_sequencer_checker (
    input logic clk_i,
    input logic rst_i,
    input logic csel_mode_i,
    input logic csel_i,
    input logic jumper_slave_i,
    input logic jumper_slave_present_i,
    input logic wb_cyc_i,
    input logic wb_stb_i,
    input logic wb_ack_o,
    input logic is_slave_o,
    input logic assume_slave_o,
    input logic spindle_on_o,
    input logic bus_response_o,
    input logic head_actuator_motor_o,
    input logic system_area_seek_o,
    input logic calibrate_o,
    input logic ready_o,
    input logic fail_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_one_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    csel_master_a: assert property ($fell(rst_i) && csel_mode_i && !csel_i |=> !is_slave_o)
        else $error("cable select low not master");
    csel_slave_a: assert property ($fell(rst_i) && csel_mode_i && csel_i |=> is_slave_o)
        else $error("cable select high not slave");
    jumper_role_a: assert property ($fell(rst_i) && !csel_mode_i |=> is_slave_o == $past(jumper_slave_i))
        else $error("jumper role wrong");
    assume_slave_a: assert property ($fell(rst_i) && !csel_mode_i && !jumper_slave_i && jumper_slave_present_i
        |=> assume_slave_o) else $error("slave presence not assumed");
    spin_start_a: assert property ($rose(spindle_on_o) |-> bus_response_o && !fail_o)
        else $error("spindle start wrong");
    unlock_order_a: assert property (head_actuator_motor_o |-> spindle_on_o) else $error("unlock without spin");
    cal_order_a: assert property ($rose(calibrate_o) |-> $past(system_area_seek_o) && !system_area_seek_o)
        else $error("calibration before info read");
    ready_order_a: assert property ($rose(ready_o) |-> $past(calibrate_o) && !calibrate_o)
        else $error("ready before calibration");
    ready_hold_a: assert property (ready_o |=> ready_o) else $error("ready dropped");
    fail_block_a: assert property (fail_o |-> !spindle_on_o && !ready_o) else $error("fail not blocking");
    cover property ($rose(ready_o));
    cover property ($rose(fail_o));
    cover property ($rose(head_actuator_motor_o));
endmodule
bind dps_sequencer dps_sequencer_checker dps_sequencer_checker_inst (.clk_i(clk_i), .rst_i(rst_i),
    .csel_mode_i(csel_mode_i), .csel_i(csel_i), .jumper_slave_i(jumper_slave_i),
    .jumper_slave_present_i(jumper_slave_present_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .is_slave_o(is_slave_o), .assume_slave_o(assume_slave_o), .spindle_on_o(spindle_on_o),
    .bus_response_o(bus_response_o), .head_actuator_motor_o(head_actuator_motor_o),
    .system_area_seek_o(system_area_seek_o), .calibrate_o(calibrate_o), .ready_o(ready_o), .fail_o(fail_o));

// ### bench/dps_sequencer_bench.sv
// Self-checking bench for the power-up sequencer.
// Assumes a one-cycle Wishbone answer and firmware-driven CTRL steps.
`timescale 1ns/100ps
`include "dps_defs.vh"
module dps_sequencer_bench;
    reg clk_i = 0, rst_i = 1, cm = 0, cs = 0, js = 0, clip = 0, sp = 0;
    reg cyc = 0, stb = 0, we = 0;
    reg [7:0] adr = 8'h00;
    reg [31:0] dat = 32'h0000_0000;
    reg [15:0] per = 16'h0000;
    wire [31:0] rdat;
    wire [15:0] drv;
    wire ack, slv, asl, spin, resp, head, seek, cal, rdy, fl, pls, cok;
    integer err_total = 0, n_tests = 0, npls = 0;
    always #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) if (pls) npls <= npls + 1;
    dps_sequencer dps_sequencer_inst (.clk_i(clk_i), .rst_i(rst_i), .csel_mode_i(cm), .csel_i(cs),
        .jumper_slave_i(js), .jumper_clip_i(clip), .jumper_slave_present_i(sp), .speed_pulse_i(pls),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .is_slave_o(slv), .assume_slave_o(asl), .spindle_on_o(spin),
        .spindle_drive_o(drv), .bus_response_o(resp), .head_actuator_motor_o(head), .system_area_seek_o(seek),
        .calibrate_o(cal), .ready_o(rdy), .fail_o(fl));
    dps_spindle_model dps_spindle_model_inst (.clk_i(clk_i), .spin_i(spin), .period_i(per), .ready_i(rdy),
        .pulse_o(pls), .cmd_ok_o(cok));
    task tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wb(input w, input [7:0] a, input [31:0] d, output [31:0] q);
        integer k;
        @(posedge clk_i);
        cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
        k = 0;
        do begin @(posedge clk_i); k = k + 1; end while (ack !== 1'b1 && k < 20);
        if (k >= 20) begin err_total = err_total + 1; tally_and_finish; end
        q = rdat;
        cyc <= 0; stb <= 0; we <= 0;
    endtask
    task do_reset(input [4:0] s);
        @(posedge clk_i);
        rst_i <= 1; per <= 16'h0000; {cm, cs, js, clip, sp} <= s;
        repeat (16) @(posedge clk_i);
        rst_i <= 0;
        repeat (3) @(posedge clk_i);
    endtask
    task t_straps;
        reg [31:0] q;
        reg [6:0] r;
        integer i;
        for (i = 0; i < 5; i = i + 1) begin
            case (i)
                0: r = 7'b10101_01;
                1: r = 7'b11011_10;
                2: r = 7'b01000_00;
                3: r = 7'b00110_10;
                default: r = 7'b00001_01;
            endcase
            do_reset(r[6:2]);
            chk({slv, asl}, r[1:0]);
            wb(0, `DPS_REG_GEOM, 0, q);
            chk(q, r[3] ? {16'h0FFC, 8'h10, 8'h3F} : {16'hFFFF, 8'h10, 8'h3F});
        end
        wb(0, 8'h20, 0, q);
        chk(q, 32'h0000_0000);
        $display("strap test done");
    endtask
    task t_fail;
        reg [31:0] q;
        do_reset(5'h00);
        wb(1, `DPS_REG_CTRL, 32'h0000_0003, q);
        repeat (5) @(posedge clk_i);
        chk(spin, 0);
        wb(1, `DPS_REG_CTRL, 32'h0000_0083, q);
        wb(1, `DPS_REG_CTRL, 32'h0000_00FF, q);
        repeat (5) @(posedge clk_i);
        chk({fl, spin, rdy}, 3'b100);
        $display("failure test done");
    endtask
    task t_seq;
        reg [31:0] q;
        integer k;
        do_reset(5'h00);
        wb(1, `DPS_REG_TARGET, 32'd100, q);
        wb(1, `DPS_REG_CTRL, 32'h0000_000F, q);
        repeat (5) @(posedge clk_i);
        chk({spin, resp, head}, 3'b110);
        wb(1, `DPS_REG_CTRL, 32'h0000_001F, q);
        repeat (40) @(posedge clk_i);
        chk(head, 0);
        per <= 16'd120;
        for (k = 0; k < 2000 && head !== 1'b1; k = k + 1) @(posedge clk_i);
        chk({head, seek, cal, rdy, cok}, 5'b11000);
        repeat (300) @(posedge clk_i);
        for (k = 0; k < 200 && pls !== 1'b1; k = k + 1) @(posedge clk_i);
        repeat (50) @(posedge clk_i);
        wb(0, `DPS_REG_DRIVE, 0, q);
        chk({drv, q[15:0]}, {2{16'h0010 * npls[15:0]}});
        wb(0, `DPS_REG_PERIOD, 0, q);
        chk(q, {16'h0000, per - 16'h0001});
        wb(1, `DPS_REG_CTRL, 32'h0000_003F, q);
        repeat (3) @(posedge clk_i);
        chk({seek, cal, rdy}, 3'b010);
        wb(1, `DPS_REG_CTRL, 32'h0000_007F, q);
        repeat (3) @(posedge clk_i);
        chk({cal, rdy, cok}, 3'b011);
        $display("sequence test done");
    endtask
    initial begin
        t_straps;
        t_fail;
        t_seq;
        tally_and_finish;
    end
endmodule

// ### bench/dps_spindle_model.sv
// Far-side model: spindle pulse source and a host that waits for ready.
// Assumes period_i is zero to keep the motor silent.
`timescale 1ns/100ps
module dps_spindle_model (
    input  logic        clk_i,
    input  logic        spin_i,
    input  logic [15:0] period_i,
    input  logic        ready_i,
    output logic        pulse_o,
    output logic        cmd_ok_o
);
    logic [15:0] cnt = 16'h0000;
    initial pulse_o = 1'b0;
    initial cmd_ok_o = 1'b0;
    // One pulse per revolution; a stopped motor gives no pulses at all.
    always @(posedge clk_i) begin
        cnt <= (spin_i && period_i != 16'h0000 && cnt < period_i - 16'h0001) ? cnt + 16'h0001 : 16'h0000;
        pulse_o <= spin_i && period_i != 16'h0000 && cnt == period_i - 16'h0001;
    end
    // The host issues commands only once ready is seen.
    always @(posedge clk_i) cmd_ok_o <= ready_i;
endmodule

// ### pkg/dps_defs.vh
// Constants for the drive power-up and configuration sequencer.
// Assumes a 200 MHz clock and a 32-bit classic Wishbone register bus.
`ifndef DPS_DEFS_VH
`define DPS_DEFS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define DPS_REG_CTRL       8'h00
`define DPS_REG_STATUS     8'h04
`define DPS_REG_GEOM       8'h08
`define DPS_REG_TARGET     8'h0C
`define DPS_REG_PERIOD     8'h10
`define DPS_REG_DRIVE      8'h14

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define DPS_CTRL_START     0
`define DPS_CTRL_BUSOK     1
`define DPS_CTRL_REGOK     2
`define DPS_CTRL_RAMOK     3
`define DPS_CTRL_BUFOK     4
`define DPS_CTRL_SAOK      5
`define DPS_CTRL_CALOK     6
`define DPS_CTRL_FAIL      7
`define DPS_CTRL_RESET     32'h0000_0000

// ----------------------------------------
// Geometry and speed figures
// ----------------------------------------
`define DPS_CLIP_CYL       16'h0FFC
`define DPS_CLIP_HEADS     8'h10
`define DPS_CLIP_SECT      8'h3F
`define DPS_FULL_CYL       16'hFFFF
`define DPS_FULL_HEADS     8'h10
`define DPS_FULL_SECT      8'h3F
`define DPS_RATED_RPM      32'h0000_1C20
`define DPS_CLK_HZ         32'h0BEB_C200
// One revolution at rated speed, in clock cycles: 60 * f / rpm.
// The product overflows 32-bit arithmetic, so the quotient 1,666,666 is given directly.
`define DPS_REV_CYCLES     32'h0019_6E6A
`define DPS_SPEED_TOL      32'h0000_4000
`define DPS_DRIVE_STEP     16'h0010

`endif

// ### verilog/dps_sequencer.v
// Power-up sequencer, strap decode and spindle speed loop for a drive.
// Assumes straps and the back-EMF or servo-mark pulse are synchronous to clk_i.
//
// The Wishbone interface to the registers and the address map are this design's own decisions.
`timescale 1ns/100ps
`include "dps_defs.vh"

module dps_sequencer (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        csel_mode_i,
    input  wire        csel_i,
    input  wire        jumper_slave_i,
    input  wire        jumper_clip_i,
    input  wire        jumper_slave_present_i,
    input  wire        speed_pulse_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    output reg         is_slave_o,
    output reg         assume_slave_o,
    output reg         spindle_on_o,
    output reg  [15:0] spindle_drive_o,
    output reg         bus_response_o,
    output reg         head_actuator_motor_o,
    output reg         system_area_seek_o,
    output reg         calibrate_o,
    output reg         ready_o,
    output reg         fail_o
);

    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam [3:0] ST_IDLE  = 4'h0;
    localparam [3:0] ST_BUS   = 4'h1;
    localparam [3:0] ST_REG   = 4'h2;
    localparam [3:0] ST_RAM   = 4'h3;
    localparam [3:0] ST_BUF   = 4'h4;
    localparam [3:0] ST_SPIN  = 4'h5;
    localparam [3:0] ST_SA    = 4'h6;
    localparam [3:0] ST_CAL   = 4'h7;
    localparam [3:0] ST_READY = 4'h8;
    localparam [3:0] ST_FAIL  = 4'h9;

    reg  [3:0]  state;
    reg  [31:0] ctrl;
    reg  [31:0] target_period;
    reg  [31:0] period_cnt;
    reg  [31:0] last_period;
    reg         pulse_q;
    reg         at_speed;
    reg         straps_taken;
    reg  [31:0] next_rdata;
    wire        wb_req;
    wire        wb_wr;
    wire        pulse_rise;

    // Word-aligned decode shared by read and write paths.
    function hit;
        input [7:0] adr;
        input [7:0] off;
        begin
            hit = (adr[7:2] == off[7:2]);
        end
    endfunction

    function [31:0] merge;
        input [31:0] old;
        input [31:0] dat;
        input [3:0]  sel;
        integer k;
        begin
            merge = old;
            for (k = 0; k < 4; k = k + 1) begin
                if (sel[k]) begin
                    merge[k*8 +: 8] = dat[k*8 +: 8];
                end
            end
        end
    endfunction

    assign wb_req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wb_wr      = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
    assign pulse_rise = speed_pulse_i & ~pulse_q;

    // ----------------------------------------
    // Wishbone slave
    // ----------------------------------------
    // Unmapped addresses are acknowledged and read as zero; writes to them are dropped.
    always @* begin
        next_rdata = 32'h0000_0000;
        if (hit(wb_adr_i, `DPS_REG_CTRL)) begin
            next_rdata = ctrl;
        end else if (hit(wb_adr_i, `DPS_REG_STATUS)) begin
            next_rdata = {16'h0000, 4'h0, state, ready_o, fail_o, at_speed, calibrate_o,
                          system_area_seek_o, head_actuator_motor_o, bus_response_o, spindle_on_o};
        end else if (hit(wb_adr_i, `DPS_REG_GEOM)) begin
            if (jumper_clip_i) begin
                next_rdata = {`DPS_CLIP_CYL, `DPS_CLIP_HEADS, `DPS_CLIP_SECT};
            end else begin
                next_rdata = {`DPS_FULL_CYL, `DPS_FULL_HEADS, `DPS_FULL_SECT};
            end
        end else if (hit(wb_adr_i, `DPS_REG_TARGET)) begin
            next_rdata = target_period;
        end else if (hit(wb_adr_i, `DPS_REG_PERIOD)) begin
            next_rdata = last_period;
        end else if (hit(wb_adr_i, `DPS_REG_DRIVE)) begin
            next_rdata = {16'h0000, spindle_drive_o};
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o      <= 1'b0;
            wb_dat_o      <= 32'h0000_0000;
            ctrl          <= `DPS_CTRL_RESET;
            target_period <= `DPS_REV_CYCLES;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req) begin
                wb_dat_o <= next_rdata;
            end
            // Writes land on the edge where the master sees ack.
            // A request withdrawn before its answer leaves the registers untouched.
            if (wb_wr && hit(wb_adr_i, `DPS_REG_CTRL)) begin
                ctrl <= merge(ctrl, wb_dat_i, wb_sel_i);
            end
            if (wb_wr && hit(wb_adr_i, `DPS_REG_TARGET)) begin
                target_period <= merge(target_period, wb_dat_i, wb_sel_i);
            end
        end
    end

    // ----------------------------------------
    // Strap decode
    // ----------------------------------------
    // Straps are caught once after reset release, as jumpers are not meant to change live.
    always @(posedge clk_i) begin
        if (rst_i) begin
            straps_taken   <= 1'b0;
            is_slave_o     <= 1'b0;
            assume_slave_o <= 1'b0;
        end else if (!straps_taken) begin
            straps_taken <= 1'b1;
            if (csel_mode_i) begin
                is_slave_o <= csel_i;
            end else begin
                is_slave_o <= jumper_slave_i;
            end
            assume_slave_o <= jumper_slave_present_i &
                              (csel_mode_i ? ~csel_i : ~jumper_slave_i);
        end
    end

    // ----------------------------------------
    // Spindle speed loop
    // ----------------------------------------
    // A plain bang-bang step keeps the loop small; firmware may trim the target period.
    always @(posedge clk_i) begin
        if (rst_i) begin
            pulse_q         <= 1'b0;
            period_cnt      <= 32'h0000_0000;
            last_period     <= 32'h0000_0000;
            at_speed        <= 1'b0;
            spindle_drive_o <= 16'h0000;
        end else begin
            pulse_q <= speed_pulse_i;
            if (!spindle_on_o) begin
                period_cnt      <= 32'h0000_0000;
                at_speed        <= 1'b0;
                spindle_drive_o <= 16'h0000;
            end else if (pulse_rise) begin
                period_cnt  <= 32'h0000_0000;
                last_period <= period_cnt;
                at_speed    <= (period_cnt + `DPS_SPEED_TOL >= target_period) &&
                               (period_cnt <= target_period + `DPS_SPEED_TOL);
                // The ceiling stops one step short of the top so the drive never wraps to zero.
                if (period_cnt > target_period && spindle_drive_o < 16'hFFF0) begin
                    spindle_drive_o <= spindle_drive_o + `DPS_DRIVE_STEP;
                end else if (period_cnt < target_period && spindle_drive_o >= `DPS_DRIVE_STEP) begin
                    spindle_drive_o <= spindle_drive_o - `DPS_DRIVE_STEP;
                end
            end else if (period_cnt != 32'hFFFF_FFFF) begin
                period_cnt <= period_cnt + 32'h0000_0001;
            end
        end
    end

    // ----------------------------------------
    // Power-on sequence
    // ----------------------------------------
    // Each step except ST_SPIN, which waits for at_speed, waits for firmware to report its outcome through the control register.
    always @(posedge clk_i) begin
        if (rst_i) begin
            state                 <= ST_IDLE;
            spindle_on_o          <= 1'b0;
            bus_response_o        <= 1'b0;
            head_actuator_motor_o <= 1'b0;
            system_area_seek_o    <= 1'b0;
            calibrate_o           <= 1'b0;
            ready_o               <= 1'b0;
            fail_o                <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (ctrl[`DPS_CTRL_START] && straps_taken) begin
                        state <= ST_BUS;
                    end
                end
                ST_BUS: begin
                    if (ctrl[`DPS_CTRL_FAIL]) begin
                        state <= ST_FAIL;
                    end else if (ctrl[`DPS_CTRL_BUSOK]) begin
                        state <= ST_REG;
                    end
                end
                ST_REG: begin
                    if (ctrl[`DPS_CTRL_FAIL]) begin
                        state <= ST_FAIL;
                    end else if (ctrl[`DPS_CTRL_REGOK]) begin
                        state <= ST_RAM;
                    end
                end
                ST_RAM: begin
                    if (ctrl[`DPS_CTRL_FAIL]) begin
                        state <= ST_FAIL;
                    end else if (ctrl[`DPS_CTRL_RAMOK]) begin
                        spindle_on_o   <= 1'b1;
                        bus_response_o <= 1'b1;
                        state          <= ST_BUF;
                    end
                end
                ST_BUF: begin
                    if (ctrl[`DPS_CTRL_FAIL]) begin
                        state <= ST_FAIL;
                    end else if (ctrl[`DPS_CTRL_BUFOK]) begin
                        state <= ST_SPIN;
                    end
                end
                ST_SPIN: begin
                    if (at_speed) begin
                        head_actuator_motor_o <= 1'b1;
                        system_area_seek_o    <= 1'b1;
                        state                 <= ST_SA;
                    end
                end
                ST_SA: begin
                    if (ctrl[`DPS_CTRL_SAOK]) begin
                        system_area_seek_o <= 1'b0;
                        calibrate_o        <= 1'b1;
                        state              <= ST_CAL;
                    end
                end
                ST_CAL: begin
                    if (ctrl[`DPS_CTRL_CALOK]) begin
                        calibrate_o <= 1'b0;
                        ready_o     <= 1'b1;
                        state       <= ST_READY;
                    end
                end
                ST_READY: begin
                    state <= ST_READY;
                end
                ST_FAIL: begin
                    spindle_on_o   <= 1'b0;
                    ready_o        <= 1'b0;
                    fail_o         <= 1'b1;
                    state          <= ST_FAIL;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

endmodule
